// ### inc/nand_feature_cfg.svh
// Operation
// RULE_01 - with protect pin low and guard set, guard and lock range refuse changes
// RULE_02 - lock range 000 none, 001..110 upper 1/64..1/2, 111 every block locked
// RULE_03 - lock range comes up as 111 so all blocks start locked
// RULE_04 - protect enable 1 lets the one-time protect command be accepted
// RULE_05 - identification read enable 1 switches page reads to parameter and id mode
// RULE_06 - bit 4 of mode register enables internal correction, default 1
// RULE_07 - bad block inhibit flag is read-only and reads 1
// RULE_08 - fast read enable turns on high-speed page reads, default 1
// RULE_09 - set-feature writes, get-feature reads, each followed by register address
// RULE_10 - written values survive reset commands, defaults only after power-on
// RULE_11 - reserved bits of both registers always read 0
// RULE_12 - writes to the read-only flag and reserved bits are ignored
`ifndef NAND_FEATURE_CFG_SVH
`define NAND_FEATURE_CFG_SVH

// -----------------------------------------------------------------------------
// serial commands and register addresses
// -----------------------------------------------------------------------------
`define FEAT_CMD_SET 8'h1f
`define FEAT_CMD_GET 8'h0f
`define FEAT_CMD_PROTECT 8'h2a
`define FEAT_ADDR_LOCK 8'ha0
`define FEAT_ADDR_MODE 8'hb0

// -----------------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------------
`define LOCK_GUARD_BIT 7
`define LOCK_RANGE_MSB 5
`define LOCK_RANGE_LSB 3
`define MODE_PROTECT_BIT 7
`define MODE_IDREAD_BIT 6
`define MODE_ECC_BIT 4
`define MODE_BBI_BIT 2
`define MODE_FAST_BIT 1

// -----------------------------------------------------------------------------
// power-on values and sizes
// -----------------------------------------------------------------------------
`define LOCK_GUARD_RESET 1'h0
`define LOCK_RANGE_RESET 3'h7
`define LOCK_RANGE_NONE 3'h0
`define LOCK_RANGE_ALL 3'h7
`define MODE_PROTECT_RESET 1'h0
`define MODE_IDREAD_RESET 1'h0
`define MODE_ECC_RESET 1'h1
`define MODE_BBI_VALUE 1'h1
`define MODE_FAST_RESET 1'h1
`define BLOCK_ADDR_W 11

`endif

// ### inc/nand_feature_pkg.sv
`default_nettype none

package nand_feature_pkg;
    // serial frame phases
    typedef enum logic [2:0] {
        ST_CMD,
        ST_ADDR,
        ST_DATA,
        ST_GET,
        ST_IGNORE
    } frame_state_t;
endpackage : nand_feature_pkg

`default_nettype wire

// ### core/nand_feature_regs.sv
`include "nand_feature_cfg.svh"
`default_nettype none

module nand_feature_regs (
    // clock and power-on reset
    input wire logic clk_in,
    input wire logic rst_in,
    // serial interface
    input wire logic cs_n_in,
    input wire logic si_in,
    output logic so_out,
    output logic so_oe_n_out,
    // protect pin
    input wire logic wp_n_in,
    // block lock query
    input wire logic [`BLOCK_ADDR_W-1:0] block_addr_in,
    output logic block_locked_out,
    // feature controls to the array logic
    output logic lock_write_guard_out,
    output logic [2:0] lock_range_out,
    output logic protect_enable_out,
    output logic protect_cmd_out,
    output logic identification_read_enable_out,
    output logic ecc_enable_out,
    output logic bad_block_inhibit_flag_out,
    output logic fast_read_enable_out
);
    import nand_feature_pkg::*;

    // -------------------------------------------------------------------------
    // functions
    // -------------------------------------------------------------------------

    // readback value of a feature address; unknown addresses read zero
    function automatic logic [7:0] read_value(input logic [7:0] addr, input logic guard,
                                              input logic [2:0] range, input logic prt,
                                              input logic idr, input logic ecc, input logic fast);
        logic [7:0] v;
        v = 8'h00; // reserved bits stay zero, see RULE_11
        if (addr == `FEAT_ADDR_LOCK) begin
            v[`LOCK_GUARD_BIT] = guard;
            v[`LOCK_RANGE_MSB:`LOCK_RANGE_LSB] = range;
        end else if (addr == `FEAT_ADDR_MODE) begin
            v[`MODE_PROTECT_BIT] = prt;
            v[`MODE_IDREAD_BIT] = idr;
            v[`MODE_ECC_BIT] = ecc;
            v[`MODE_BBI_BIT] = `MODE_BBI_VALUE; // see RULE_07
            v[`MODE_FAST_BIT] = fast;
        end
        return v;
    endfunction : read_value

    // a block is locked when range is not 000 and its top (7 - range) address bits are all ones
    function automatic logic block_in_range(input logic [2:0] range,
                                            input logic [`BLOCK_ADDR_W-1:0] blk);
        logic hit;
        hit = 1'b1;
        if (range == `LOCK_RANGE_NONE) begin
            hit = 1'b0;
        end else if (range != `LOCK_RANGE_ALL) begin
            for (int i = 0; i < 6; i++) begin
                if (i < 7 - int'(range)) begin
                    hit = hit & blk[`BLOCK_ADDR_W-1-i];
                end
            end
        end
        return hit; // see RULE_02
    endfunction : block_in_range

    // -------------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------------
    frame_state_t state_ff, nxt_state;
    logic [2:0] cnt_ff, nxt_cnt;
    logic [7:0] in_sh_ff, nxt_in_sh;
    logic [7:0] out_sh_ff, nxt_out_sh;
    logic [7:0] addr_ff, nxt_addr;
    logic is_set_ff, nxt_is_set;
    logic oe_n_ff, nxt_oe_n;
    logic prot_cmd_ff, nxt_prot_cmd;
    logic guard_ff, nxt_guard;
    logic [2:0] range_ff, nxt_range;
    logic prt_ff, nxt_prt;
    logic idr_ff, nxt_idr;
    logic ecc_ff, nxt_ecc;
    logic fast_ff, nxt_fast;
    logic bbi_ff;
    logic locked_ff, nxt_locked;
    logic [7:0] byte_in;
    logic byte_done;

    assign byte_in = {in_sh_ff[6:0], si_in};
    assign byte_done = (cnt_ff == 3'h7);

    // -------------------------------------------------------------------------
    // frame decoder and feature registers: next values
    // -------------------------------------------------------------------------

    // one byte every eight edges, msb first; a frame ends only when select rises
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = 3'(cnt_ff + 3'h1);
        nxt_in_sh = byte_in;
        nxt_out_sh = out_sh_ff;
        nxt_addr = addr_ff;
        nxt_is_set = is_set_ff;
        nxt_oe_n = oe_n_ff;
        nxt_prot_cmd = 1'b0;
        nxt_guard = guard_ff;
        nxt_range = range_ff;
        nxt_prt = prt_ff;
        nxt_idr = idr_ff;
        nxt_ecc = ecc_ff;
        nxt_fast = fast_ff;
        nxt_locked = block_in_range(range_ff, block_addr_in);
        if (cs_n_in) begin
            nxt_state = ST_CMD;
            nxt_cnt = 3'h0;
            nxt_oe_n = 1'b1;
        end else begin
            case (state_ff)
                ST_CMD: begin
                    if (byte_done) begin
                        nxt_is_set = (byte_in == `FEAT_CMD_SET); // see RULE_09
                        if (byte_in == `FEAT_CMD_SET || byte_in == `FEAT_CMD_GET) begin
                            nxt_state = ST_ADDR;
                        end else begin
                            // protect pulse only while enabled, see RULE_04
                            nxt_prot_cmd = (byte_in == `FEAT_CMD_PROTECT) && prt_ff;
                            nxt_state = ST_IGNORE;
                        end
                    end
                end
                ST_ADDR: begin
                    if (byte_done) begin
                        nxt_addr = byte_in;
                        if (is_set_ff) begin
                            nxt_state = ST_DATA;
                        end else begin
                            nxt_state = ST_GET;
                            nxt_oe_n = 1'b0;
                            nxt_out_sh = read_value(byte_in, guard_ff, range_ff, prt_ff, idr_ff, ecc_ff,
                                                    fast_ff); // see RULE_09
                        end
                    end
                end
                ST_DATA: begin
                    if (byte_done) begin
                        nxt_state = ST_IGNORE; // trailing bytes are dropped
                        if (addr_ff == `FEAT_ADDR_LOCK && !(!wp_n_in && guard_ff)) begin // see RULE_01
                            nxt_guard = byte_in[`LOCK_GUARD_BIT];
                            nxt_range = byte_in[`LOCK_RANGE_MSB:`LOCK_RANGE_LSB];
                        end else if (addr_ff == `FEAT_ADDR_MODE) begin
                            // only writable bits are taken, see RULE_12
                            nxt_prt = byte_in[`MODE_PROTECT_BIT];
                            nxt_idr = byte_in[`MODE_IDREAD_BIT]; // see RULE_05
                            nxt_ecc = byte_in[`MODE_ECC_BIT]; // see RULE_06
                            nxt_fast = byte_in[`MODE_FAST_BIT]; // see RULE_08
                        end
                    end
                end
                ST_GET: begin
                    // the byte repeats until select rises, refreshed from live state
                    if (byte_done) begin
                        nxt_out_sh = read_value(addr_ff, guard_ff, range_ff, prt_ff, idr_ff, ecc_ff, fast_ff);
                    end else begin
                        nxt_out_sh = {out_sh_ff[6:0], 1'b0};
                    end
                end
                ST_IGNORE: begin
                    nxt_state = ST_IGNORE;
                end
                default: begin
                    nxt_state = ST_IGNORE;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------------

    // only power-on reset restores defaults; reset commands are not decoded here, see RULE_10
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= ST_CMD;
            cnt_ff <= 3'h0;
            in_sh_ff <= 8'h00;
            out_sh_ff <= 8'h00;
            addr_ff <= 8'h00;
            is_set_ff <= 1'b0;
            oe_n_ff <= 1'b1;
            prot_cmd_ff <= 1'b0;
            guard_ff <= `LOCK_GUARD_RESET;
            range_ff <= `LOCK_RANGE_RESET; // see RULE_03
            prt_ff <= `MODE_PROTECT_RESET;
            idr_ff <= `MODE_IDREAD_RESET;
            ecc_ff <= `MODE_ECC_RESET;
            fast_ff <= `MODE_FAST_RESET;
            bbi_ff <= `MODE_BBI_VALUE;
            locked_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            in_sh_ff <= nxt_in_sh;
            out_sh_ff <= nxt_out_sh;
            addr_ff <= nxt_addr;
            is_set_ff <= nxt_is_set;
            oe_n_ff <= nxt_oe_n;
            prot_cmd_ff <= nxt_prot_cmd;
            guard_ff <= nxt_guard;
            range_ff <= nxt_range;
            prt_ff <= nxt_prt;
            idr_ff <= nxt_idr;
            ecc_ff <= nxt_ecc;
            fast_ff <= nxt_fast;
            bbi_ff <= `MODE_BBI_VALUE; // read-only, see RULE_07
            locked_ff <= nxt_locked;
        end
    end

    // -------------------------------------------------------------------------
    // outputs, all straight from flops
    // -------------------------------------------------------------------------
    assign so_out = out_sh_ff[7];
    assign so_oe_n_out = oe_n_ff;
    assign block_locked_out = locked_ff;
    assign lock_write_guard_out = guard_ff;
    assign lock_range_out = range_ff;
    assign protect_enable_out = prt_ff;
    assign protect_cmd_out = prot_cmd_ff;
    assign identification_read_enable_out = idr_ff;
    assign ecc_enable_out = ecc_ff;
    assign bad_block_inhibit_flag_out = bbi_ff;
    assign fast_read_enable_out = fast_ff;

endmodule : nand_feature_regs

`default_nettype wire

// ### tb/nand_feature_regs_checker.sv
`include "nand_feature_cfg.svh"
`default_nettype none
module nand_feature_regs_checker (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // watched ports
    input wire logic cs_n_in,
    input wire logic wp_n_in,
    input wire logic [`BLOCK_ADDR_W-1:0] block_addr_in,
    input wire logic so_oe_n_out,
    input wire logic block_locked_out,
    input wire logic lock_write_guard_out,
    input wire logic [2:0] lock_range_out,
    input wire logic protect_enable_out,
    input wire logic protect_cmd_out,
    input wire logic identification_read_enable_out,
    input wire logic ecc_enable_out,
    input wire logic bad_block_inhibit_flag_out,
    input wire logic fast_read_enable_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] bits_ff;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // bits taken in this frame; saturates so a long read cannot wrap to a false 24
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bits_ff <= 5'h00;
        end else begin
            bits_ff <= cs_n_in ? 5'h00 : bits_ff + {4'h0, bits_ff != 5'h1f};
        end
    end
    bbi_const_a: assert property (bad_block_inhibit_flag_out) else $error("inhibit flag low");
    prot_gate_a: assert property (protect_cmd_out |-> protect_enable_out) else $error("protect not enabled");
    prot_pulse_a: assert property (protect_cmd_out |=> !protect_cmd_out) else $error("protect pulse long");
    range_none_a: assert property ((lock_range_out == 3'h0)[*2] |-> !block_locked_out)
        else $error("locked with range none");
    range_all_a: assert property ((lock_range_out == 3'h7)[*2] |-> block_locked_out)
        else $error("unlocked with range all");
    range_map_a: assert property ($stable(lock_range_out) && lock_range_out != 3'h0 && lock_range_out != 3'h7
        |-> block_locked_out == (($past(block_addr_in) >> (`BLOCK_ADDR_W - 7 + lock_range_out))
        == ((11'h1 << (7 - lock_range_out)) - 11'h1))) else $error("lock range decode");
    guard_hold_a: assert property (!wp_n_in && lock_write_guard_out |=> $stable(lock_range_out)
        && lock_write_guard_out) else $error("guarded lock changed");
    oe_window_a: assert property (!so_oe_n_out |-> bits_ff >= 5'd16) else $error("output enabled early");
    update_edge_a: assert property ($changed({lock_write_guard_out, lock_range_out, protect_enable_out,
        identification_read_enable_out, ecc_enable_out, fast_read_enable_out}) |-> bits_ff == 5'd24)
        else $error("feature changed off data edge");
    cover property (protect_cmd_out);
    cover property (!so_oe_n_out);
    cover property (!wp_n_in && lock_write_guard_out && bits_ff == 5'd24);
endmodule : nand_feature_regs_checker
`default_nettype wire

// ### tb/host_model.sv
`default_nettype none
module host_model (
    // serial clock
    input wire logic clk_in,
    // lines to the device
    output logic cs_n_out,
    output logic si_out,
    // lines back from the device
    input wire logic so_in,
    input wire logic so_oe_n_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cs_n_out = 1'b1;
        si_out = 1'b0;
    end
    // one frame msb first; data phase read mid-cycle where so is settled, and an
    // undriven so is taken inverted so a missing enable cannot pass
    task automatic frame(input logic [23:0] v, input int nbits, output logic [7:0] rd);
        rd = 8'h00;
        for (int i = 0; i < nbits; i++) begin
            cs_n_out <= 1'b0;
            si_out <= v[23-i];
            @(negedge clk_in);
            if (i >= 16) begin
                rd[23-i] = so_oe_n_in ? ~so_in : so_in;
            end
            @(posedge clk_in);
        end
        cs_n_out <= 1'b1;
        si_out <= ~si_out;
        @(posedge clk_in);
    endtask : frame
endmodule : host_model
`default_nettype wire

// ### tb/test_nand_feature_regs.sv
`include "nand_feature_cfg.svh"
`default_nettype none
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_fail++; $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module test_nand_feature_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import nand_feature_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in, cs_n, si, so, so_oe_n, wp_n_in, locked, guard, prt, prt_cmd, idr, ecc, bad_block_inhibit_flag, fast;
    logic pulse_seen = 1'b0;
    logic [2:0] range;
    logic [10:0] block_addr_in;
    logic [7:0] rd;
    int n_fail = 0;
    int n_compared = 0;
    // ----------------------------------------
    // clock, parts and helpers
    // ----------------------------------------
    always #10 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        if (prt_cmd === 1'b1) pulse_seen <= 1'b1;
    end
    host_model host (.clk_in(clk_in), .cs_n_out(cs_n), .si_out(si), .so_in(so), .so_oe_n_in(so_oe_n));
    nand_feature_regs dut (.clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n), .si_in(si), .so_out(so),
        .so_oe_n_out(so_oe_n), .wp_n_in(wp_n_in), .block_addr_in(block_addr_in), .block_locked_out(locked),
        .lock_write_guard_out(guard), .lock_range_out(range), .protect_enable_out(prt), .protect_cmd_out(prt_cmd),
        .identification_read_enable_out(idr), .ecc_enable_out(ecc), .bad_block_inhibit_flag_out(bad_block_inhibit_flag),
        .fast_read_enable_out(fast));
    task automatic set_feat(input logic [7:0] a, input logic [7:0] d);
        host.frame({`FEAT_CMD_SET, a, d}, 24, rd);
    endtask : set_feat
    task automatic get_feat(input logic [7:0] a, input logic [7:0] exp);
        host.frame({`FEAT_CMD_GET, a, 8'h00}, 24, rd);
        `CHECK(rd, exp)
    endtask : get_feat
    task automatic query(input logic [10:0] a, input logic exp);
        block_addr_in <= a;
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        `CHECK(locked, exp)
        @(posedge clk_in);
    endtask : query
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic reset_values();
        `CHECK({guard, range, prt, idr, ecc, bad_block_inhibit_flag, fast}, 9'h0e7)
        get_feat(`FEAT_ADDR_LOCK, 8'h38);
        get_feat(`FEAT_ADDR_MODE, 8'h16);
        get_feat(8'h55, 8'h00);
        // a write to an address outside the two registers must leave every field alone
        set_feat(8'h55, 8'hff);
        `CHECK({guard, range, prt, idr, ecc, bad_block_inhibit_flag, fast}, 9'h0e7)
    endtask : reset_values
    task automatic mode_write();
        set_feat(`FEAT_ADDR_MODE, 8'hff);
        get_feat(`FEAT_ADDR_MODE, 8'hd6);
        `CHECK({prt, idr, ecc, bad_block_inhibit_flag, fast}, 5'h1f)
        host.frame({`FEAT_CMD_PROTECT, 16'h0000}, 8, rd);
        @(posedge clk_in); // the sticky flag lands one edge after the pulse is seen
        `CHECK(pulse_seen, 1'b1)
        set_feat(`FEAT_ADDR_MODE, 8'h00);
        get_feat(`FEAT_ADDR_MODE, 8'h04);
        `CHECK({prt, idr, ecc, bad_block_inhibit_flag, fast}, 5'h02)
        pulse_seen <= 1'b0;
        host.frame({`FEAT_CMD_PROTECT, 16'h0000}, 8, rd);
        @(posedge clk_in); // give a stray pulse the same edge to show up
        `CHECK(pulse_seen, 1'b0)
    endtask : mode_write
    task automatic lock_ranges();
        logic [10:0] edge_a;
        for (int r = 0; r < 8; r++) begin
            set_feat(`FEAT_ADDR_LOCK, {2'b01, r[2:0], 3'b111});
            get_feat(`FEAT_ADDR_LOCK, {2'b00, r[2:0], 3'b000});
            edge_a = (r == 0) ? 11'h7ff : ~((11'h1 << (r + 4)) - 11'h1);
            query(edge_a, r != 0);
            query(edge_a - 11'h001, r == 7);
        end
    endtask : lock_ranges
    task automatic guard_lock();
        set_feat(`FEAT_ADDR_LOCK, 8'ha0);
        wp_n_in <= 1'b0;
        set_feat(`FEAT_ADDR_LOCK, 8'h08);
        get_feat(`FEAT_ADDR_LOCK, 8'ha0);
        `CHECK({guard, range}, 4'hc)
        wp_n_in <= 1'b1;
        set_feat(`FEAT_ADDR_LOCK, 8'h08);
        get_feat(`FEAT_ADDR_LOCK, 8'h08);
    endtask : guard_lock
    task automatic reset_cmds();
        set_feat(`FEAT_ADDR_MODE, 8'h10);
        host.frame({8'hff, 16'h0000}, 8, rd);
        host.frame({8'hfe, 16'h0000}, 8, rd);
        get_feat(`FEAT_ADDR_LOCK, 8'h08);
        get_feat(`FEAT_ADDR_MODE, 8'h14);
        // only a power-on reset brings the defaults back
        rst_in <= 1'b1;
        @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        get_feat(`FEAT_ADDR_LOCK, 8'h38);
        get_feat(`FEAT_ADDR_MODE, 8'h16);
    endtask : reset_cmds
    task automatic end_of_test();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    // main sequence, then a watchdog in case a frame hangs
    initial begin
        rst_in = 1'b1;
        wp_n_in = 1'b1;
        block_addr_in = 11'h000;
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        reset_values();
        mode_write();
        lock_ranges();
        guard_lock();
        reset_cmds();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        end_of_test();
    end
endmodule : test_nand_feature_regs
bind nand_feature_regs nand_feature_regs_checker chk (.clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n_in),
    .wp_n_in(wp_n_in), .block_addr_in(block_addr_in), .so_oe_n_out(so_oe_n_out), .block_locked_out(block_locked_out),
    .lock_write_guard_out(lock_write_guard_out), .lock_range_out(lock_range_out),
    .protect_enable_out(protect_enable_out), .protect_cmd_out(protect_cmd_out),
    .identification_read_enable_out(identification_read_enable_out), .ecc_enable_out(ecc_enable_out),
    .bad_block_inhibit_flag_out(bad_block_inhibit_flag_out), .fast_read_enable_out(fast_read_enable_out));
`default_nettype wire
